// [rtl/ovd_pkg.sv]
// constants shared by the overrange detector files
package ovd_pkg;
    // sample and compare widths
    localparam int OVD_SAMPLE_W = 12;
    localparam int OVD_CMP_W = 8;
    localparam int OVD_IQ_W = 16;
    localparam int OVD_SEL_W = 3;
    // stretch length is base shifted by period select
    localparam int OVD_PULSE_BASE = 8;
    localparam int OVD_PULSE_MAX = 1024;
    localparam int OVD_CNT_W = 11;
    // embedded window counter width, holds up to 2**7 samples
    localparam int OVD_WIN_W = 8;
    // register byte offsets
    localparam logic [7:0] OVD_ADDR_THRESH = 8'h00;
    localparam logic [7:0] OVD_ADDR_CFG = 8'h04;
    localparam logic [7:0] OVD_ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] OVD_ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OVD_ADDR_FLAGS = 8'h10;
    // field positions
    localparam int OVD_THR_HIGH_LSB = 0;
    localparam int OVD_THR_LOW_LSB = 8;
    localparam int OVD_CFG_SEL_LSB = 0;
    localparam int OVD_CFG_SINGLE_BIT = 4;
    localparam int OVD_CFG_CPLX_BIT = 5;
    localparam int OVD_FLAGS_EMB_LSB = 4;
    // event bit order in status, mask and flag words
    localparam int OVD_EV_A_HIGH = 0;
    localparam int OVD_EV_A_LOW = 1;
    localparam int OVD_EV_B_HIGH = 2;
    localparam int OVD_EV_B_LOW = 3;
    // values after reset
    localparam logic [7:0] OVD_THR_HIGH_RST = 8'hff;
    localparam logic [7:0] OVD_THR_LOW_RST = 8'hff;
    localparam logic [2:0] OVD_SEL_RST = 3'h0;
    localparam logic [3:0] OVD_MASK_RST = 4'h0;
endpackage

// [rtl/ovd_magnitude.sv]
// absolute value of one two's complement sample, top bits kept
`timescale 1ns/1ps
`default_nettype none
module ovd_magnitude
    import ovd_pkg::*;
#(
    parameter int SAMPLE_W = OVD_SAMPLE_W,
    parameter int CMP_W = OVD_CMP_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // two's complement sample in
    input wire logic code_valid,
    input wire logic [SAMPLE_W-1:0] code,
    // comparison value out
    output logic mag_valid,
    output logic [CMP_W-1:0] mag
);
    // the comparison value is a slice of the magnitude, so it must fit
    if (CMP_W > SAMPLE_W - 1) begin : g_chk
        $error("ovd_magnitude: CMP_W wider than magnitude");
    end

    typedef struct packed {
        logic valid;
        logic [CMP_W-1:0] mag;
    } ovd_mag_state_type;

    ovd_mag_state_type q, d;
    logic [SAMPLE_W-1:0] neg_code; // plain negation
    logic [SAMPLE_W-1:0] abs_code; // saturated magnitude
    logic [SAMPLE_W-1:0] code_min; // most negative code
    logic [SAMPLE_W-1:0] code_max; // most positive code

    // magnitude and slice
    always_comb begin
        code_min = {1'b1, {(SAMPLE_W-1){1'b0}}};
        code_max = {1'b0, {(SAMPLE_W-1){1'b1}}};
        neg_code = ~code + {{(SAMPLE_W-1){1'b0}}, 1'b1};
        // most negative has no positive twin, so it saturates to max
        if (!code[SAMPLE_W-1]) begin
            abs_code = code;
        end else if (code == code_min) begin
            abs_code = code_max;
        end else begin
            abs_code = neg_code;
        end
        d.valid = code_valid;
        d.mag = abs_code[SAMPLE_W-2 -: CMP_W];
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign mag_valid = q.valid;
    assign mag = q.mag;
endmodule
`default_nettype wire

// [rtl/ovd_stretch.sv]
// stretches one overrange hit into a flag of selectable length
`timescale 1ns/1ps
`default_nettype none
module ovd_stretch
    import ovd_pkg::*;
#(
    parameter int CNT_W = OVD_CNT_W,
    parameter int SEL_W = OVD_SEL_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // hit in, length select
    input wire logic hit,
    input wire logic [SEL_W-1:0] sel,
    // stretched flag
    output logic flag
);
    // longest length must fit the counter
    if ((OVD_PULSE_BASE << ((1 << SEL_W) - 1)) >= (1 << (CNT_W + 1))) begin : g_chk
        $error("ovd_stretch: counter too narrow for longest pulse");
    end

    typedef struct packed {
        logic [CNT_W:0] cnt;
        logic flag;
    } ovd_str_state_type;

    ovd_str_state_type q, d;
    logic [CNT_W:0] len; // pulse length in clocks

    // reload on every hit so length runs from the last event
    always_comb begin
        len = (CNT_W+1)'(OVD_PULSE_BASE) << sel;
        d = q;
        if (hit) begin
            d.cnt = len;
            d.flag = 1'b1;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - {{CNT_W{1'b0}}, 1'b1};
            d.flag = (q.cnt > {{CNT_W{1'b0}}, 1'b1});
        end else begin
            d.flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flag = q.flag;
endmodule
`default_nettype wire

// [rtl/ovd_detector.sv]
// overrange detector: magnitude compare, flag pins, embedded flags, apb
// Behaviour
// - samples leave as signed two's complement codes
// - single mode carries two samples per clock
// - compare top 8 magnitude bits with thresholds
// - most negative code maps to full scale
// - both channels share the two thresholds
// - flag set when value reaches threshold
// - four flag pins, channel by threshold
// - flag stretched 8 shl select clocks
// - in-phase word LSB carries high flag
// - quadrature word LSB carries low flag
// - embedded flag high if window saw hit
// - embedded window is 2**select samples
`timescale 1ns/1ps
`default_nettype none
module ovd_detector
    import ovd_pkg::*;
#(
    parameter int SAMPLE_W = OVD_SAMPLE_W,
    parameter int CMP_W = OVD_CMP_W,
    parameter int IQ_W = OVD_IQ_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // raw converter codes, offset binary
    input wire logic samp_valid,
    input wire logic [SAMPLE_W-1:0] core_code_a,
    input wire logic [SAMPLE_W-1:0] core_code_b,
    // two's complement samples out
    output logic samp_out_valid,
    output logic [SAMPLE_W-1:0] samp_a,
    output logic [SAMPLE_W-1:0] samp_b,
    // complex decimator words in
    input wire logic cplx_valid,
    input wire logic [IQ_W-1:0] cplx_i_a,
    input wire logic [IQ_W-1:0] cplx_q_a,
    input wire logic [IQ_W-1:0] cplx_i_b,
    input wire logic [IQ_W-1:0] cplx_q_b,
    // complex words out with embedded flags
    output logic cplx_out_valid,
    output logic [IQ_W-1:0] cplx_out_i_a,
    output logic [IQ_W-1:0] cplx_out_q_a,
    output logic [IQ_W-1:0] cplx_out_i_b,
    output logic [IQ_W-1:0] cplx_out_q_b,
    // flag pins to the gain control logic
    output logic chan_a_flag_high,
    output logic chan_a_flag_low,
    output logic chan_b_flag_high,
    output logic chan_b_flag_low,
    // interrupt
    output logic irq
);
    // widths the logic is built around
    if (SAMPLE_W != OVD_SAMPLE_W || CMP_W != OVD_CMP_W || IQ_W < 2) begin : g_chk
        $error("ovd_detector: unsupported width parameters");
    end

    typedef struct packed {
        logic [CMP_W-1:0] thr_high; // shared high threshold
        logic [CMP_W-1:0] thr_low; // shared low threshold
        logic [OVD_SEL_W-1:0] sel; // period select
        logic single; // single-channel mode
        logic cplx_en; // complex decimation mode
        logic [3:0] irq_stat; // sticky events
        logic [3:0] irq_mask; // event enables
        logic [31:0] rdata; // read data, caught in setup
        logic code_valid; // converted sample valid
        logic [SAMPLE_W-1:0] code_a; // two's complement a
        logic [SAMPLE_W-1:0] code_b; // two's complement b
        logic [OVD_WIN_W-1:0] win_cnt; // samples seen in window
        logic [3:0] acc; // hits seen in window
        logic [3:0] emb; // embedded flags of last window
        logic iq_valid; // complex words valid
        // complex words, LSB swapped when enabled
        logic [IQ_W-1:0] i_a;
        logic [IQ_W-1:0] q_a;
        logic [IQ_W-1:0] i_b;
        logic [IQ_W-1:0] q_b;
    } ovd_state_type;

    ovd_state_type q, d;
    logic [1:0] mag_valid; // per channel magnitude valid
    logic [CMP_W-1:0] mag [2]; // per channel comparison value
    logic [SAMPLE_W-1:0] code_arr [2]; // per channel code to magnitude
    logic [3:0] hit; // per channel, per threshold hit
    logic [3:0] flag; // stretched flags
    logic addr_ok; // address decodes to a register
    logic wr_en; // write takes effect this edge
    logic [31:0] rd_mux; // read value of addressed register
    logic [OVD_WIN_W-1:0] win_last; // last sample index of window
    logic win_end; // this sample closes the window

    // codes as an array so the channel loop can index them
    assign code_arr[0] = q.code_a;
    assign code_arr[1] = q.code_b;

    // per channel magnitude and two stretchers, one per threshold
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        ovd_magnitude #(
            .SAMPLE_W(SAMPLE_W),
            .CMP_W(CMP_W)
        ) u_mag (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .code_valid(q.code_valid),
            .code(code_arr[ch]),
            .mag_valid(mag_valid[ch]),
            .mag(mag[ch])
        );
        // same pair of thresholds for both channels
        assign hit[2*ch] = mag_valid[ch] && (mag[ch] >= q.thr_high);
        assign hit[2*ch+1] = mag_valid[ch] && (mag[ch] >= q.thr_low);
        for (genvar th = 0; th < 2; th++) begin : g_th
            ovd_stretch #(
                .CNT_W(OVD_CNT_W),
                .SEL_W(OVD_SEL_W)
            ) u_str (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .hit(hit[2*ch+th]),
                .sel(q.sel),
                .flag(flag[2*ch+th])
            );
        end
    end

    // address decode; unmapped addresses answer with an error
    always_comb begin
        case (paddr)
            OVD_ADDR_THRESH, OVD_ADDR_CFG, OVD_ADDR_IRQ_STAT,
            OVD_ADDR_IRQ_MASK, OVD_ADDR_FLAGS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // read mux, unused bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OVD_ADDR_THRESH: begin
                rd_mux[OVD_THR_HIGH_LSB +: CMP_W] = q.thr_high;
                rd_mux[OVD_THR_LOW_LSB +: CMP_W] = q.thr_low;
            end
            OVD_ADDR_CFG: begin
                rd_mux[OVD_CFG_SEL_LSB +: OVD_SEL_W] = q.sel;
                rd_mux[OVD_CFG_SINGLE_BIT] = q.single;
                rd_mux[OVD_CFG_CPLX_BIT] = q.cplx_en;
            end
            OVD_ADDR_IRQ_STAT: rd_mux[3:0] = q.irq_stat;
            OVD_ADDR_IRQ_MASK: rd_mux[3:0] = q.irq_mask;
            // live pin flags and embedded flags
            OVD_ADDR_FLAGS: begin
                rd_mux[3:0] = flag;
                rd_mux[OVD_FLAGS_EMB_LSB +: 4] = q.emb;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // zero wait states: access phase always completes
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;

    // window closes after 2**sel samples; >= copes with a shrinking select
    // limitation: in single mode the window counts clocks, not samples
    assign win_last = OVD_WIN_W'((1 << q.sel) - 1);
    assign win_end = (q.win_cnt >= win_last);

    // next state
    always_comb begin
        d = q;
        // read data caught in the setup cycle so prdata comes from a flop
        if (psel && !penable) begin
            d.rdata = rd_mux;
        end
        // register writes; new values apply from the following sample
        if (wr_en && paddr == OVD_ADDR_THRESH) begin
            d.thr_high = pwdata[OVD_THR_HIGH_LSB +: CMP_W];
            d.thr_low = pwdata[OVD_THR_LOW_LSB +: CMP_W];
        end
        if (wr_en && paddr == OVD_ADDR_CFG) begin
            d.sel = pwdata[OVD_CFG_SEL_LSB +: OVD_SEL_W];
            d.single = pwdata[OVD_CFG_SINGLE_BIT];
            d.cplx_en = pwdata[OVD_CFG_CPLX_BIT];
        end
        // the mask gates only the interrupt, never the pins
        if (wr_en && paddr == OVD_ADDR_IRQ_MASK) begin
            d.irq_mask = pwdata[3:0];
        end
        // write one to clear, a hit in the same cycle wins
        if (wr_en && paddr == OVD_ADDR_IRQ_STAT) begin
            d.irq_stat = q.irq_stat & ~pwdata[3:0];
        end
        // set applied after the clear, so a new event survives
        d.irq_stat = d.irq_stat | hit;
        // offset binary to two's complement by flipping the sign bit
        d.code_valid = samp_valid;
        if (samp_valid) begin
            d.code_a = {~core_code_a[SAMPLE_W-1], core_code_a[SAMPLE_W-2:0]};
            d.code_b = {~core_code_b[SAMPLE_W-1], core_code_b[SAMPLE_W-2:0]};
        end
        // in single mode b carries the falling-edge sample, so both
        // channels see a sample every clock and the window counts clocks
        // of channel a; the flags stay per channel for the far end to OR
        if (mag_valid[0]) begin
            if (win_end) begin
                d.emb = q.acc | hit;
                d.acc = 4'h0;
                d.win_cnt = '0;
            end else begin
                d.acc = q.acc | hit;
                d.win_cnt = q.win_cnt + {{(OVD_WIN_W-1){1'b0}}, 1'b1};
            end
        end
        // complex words: LSB swapped for the embedded flag
        d.iq_valid = cplx_valid;
        if (cplx_valid) begin
            d.i_a = {cplx_i_a[IQ_W-1:1], q.cplx_en ? q.emb[OVD_EV_A_HIGH] : cplx_i_a[0]};
            d.q_a = {cplx_q_a[IQ_W-1:1], q.cplx_en ? q.emb[OVD_EV_A_LOW] : cplx_q_a[0]};
            d.i_b = {cplx_i_b[IQ_W-1:1], q.cplx_en ? q.emb[OVD_EV_B_HIGH] : cplx_i_b[0]};
            d.q_b = {cplx_q_b[IQ_W-1:1], q.cplx_en ? q.emb[OVD_EV_B_LOW] : cplx_q_b[0]};
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            // settings come up at their reset values
            q.thr_high <= OVD_THR_HIGH_RST;
            q.thr_low <= OVD_THR_LOW_RST;
            q.sel <= OVD_SEL_RST;
            q.irq_mask <= OVD_MASK_RST;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign prdata = q.rdata;
    // sample and complex words leave from flops
    assign samp_out_valid = q.code_valid;
    assign samp_a = q.code_a;
    assign samp_b = q.code_b;
    assign cplx_out_valid = q.iq_valid;
    assign cplx_out_i_a = q.i_a;
    assign cplx_out_q_a = q.q_a;
    assign cplx_out_i_b = q.i_b;
    assign cplx_out_q_b = q.q_b;
    // four pins, one per channel and threshold
    assign chan_a_flag_high = flag[OVD_EV_A_HIGH];
    assign chan_a_flag_low = flag[OVD_EV_A_LOW];
    assign chan_b_flag_high = flag[OVD_EV_B_HIGH];
    assign chan_b_flag_low = flag[OVD_EV_B_LOW];
    // level interrupt while an unmasked event is pending
    assign irq = |(q.irq_stat & q.irq_mask);

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // sample path checks
    sign_flip_a: assert property (samp_valid |=>
        samp_a == {~$past(core_code_a[SAMPLE_W-1]), $past(core_code_a[SAMPLE_W-2:0])})
        else $error("sample a not converted to two's complement");
    pos_mag_a: assert property ((q.code_valid && !q.code_a[SAMPLE_W-1]) |=>
        mag[0] == $past(q.code_a[SAMPLE_W-2 -: CMP_W]))
        else $error("positive magnitude slice wrong");
    full_neg_a: assert property ((q.code_valid && q.code_b == 12'h800) |=>
        mag[1] == 8'hff)
        else $error("most negative code not full scale");
    // flag pin checks
    high_hit_a: assert property ((mag_valid[0] && mag[0] >= q.thr_high) |=>
        chan_a_flag_high)
        else $error("channel a high flag missed");
    shared_thr_a: assert property ((mag_valid[1] && mag[1] >= q.thr_low) |=>
        chan_b_flag_low)
        else $error("channel b low flag missed");
    min_stretch_a: assert property ((hit[OVD_EV_A_LOW] && q.sel == 3'h0) |=>
        chan_a_flag_low [*8])
        else $error("flag shorter than eight clocks");
    // after the last hit at select 0 the flag drops on the ninth edge
    flag_end_a: assert property ((hit[OVD_EV_B_HIGH] && q.sel == 3'h0)
        ##1 !hit[OVD_EV_B_HIGH] [*8] |=> !chan_b_flag_high)
        else $error("flag outlived its stretch");
    // embedded flag checks
    emb_iq_a: assert property (cplx_valid |=>
        cplx_out_i_a[0] == ($past(q.cplx_en) ? $past(q.emb[0]) : $past(cplx_i_a[0]))
        && cplx_out_i_a[IQ_W-1:1] == $past(cplx_i_a[IQ_W-1:1]))
        else $error("in-phase lsb not embedded");
    emb_q_b_a: assert property ((cplx_valid && q.cplx_en) |=>
        cplx_out_q_b[0] == $past(q.emb[3]))
        else $error("quadrature lsb not embedded");
    window_hit_a: assert property ((mag_valid[0] && win_end && hit[0]) |=>
        q.emb[0] && q.win_cnt == '0)
        else $error("window hit not embedded");
    // register checks
    thr_write_a: assert property ((wr_en && paddr == OVD_ADDR_THRESH) |=>
        q.thr_high == $past(pwdata[7:0]) && q.thr_low == $past(pwdata[15:8]))
        else $error("threshold write lost");
    irq_set_a: assert property (hit[1] |=> q.irq_stat[1])
        else $error("event lost against clear");
    // window of four samples closes on every fourth sample
    win_len_a: assert property ((mag_valid[0] && win_end && q.sel == 3'h2)
        ##1 (mag_valid[0] && q.sel == 3'h2) [*4] |-> win_end
        && !$past(win_end) && !$past(win_end, 2) && !$past(win_end, 3))
        else $error("embedded window length wrong");
    sel_write_a: assert property ((wr_en && paddr == OVD_ADDR_CFG) |=>
        q.sel == $past(pwdata[OVD_CFG_SEL_LSB +: OVD_SEL_W]))
        else $error("period select write lost");
    // clearing wins only when no new event lands
    stat_clear_a: assert property ((wr_en && paddr == OVD_ADDR_IRQ_STAT
        && pwdata[OVD_EV_A_HIGH] && !hit[OVD_EV_A_HIGH]) |=> !q.irq_stat[OVD_EV_A_HIGH])
        else $error("status bit not cleared");
    // refused writes leave the high threshold, period select and mask alone
    bad_write_a: assert property ((psel && penable && pwrite && !addr_ok) |=>
        q.thr_high == $past(q.thr_high) && q.sel == $past(q.sel)
        && q.irq_mask == $past(q.irq_mask))
        else $error("unmapped write changed a register");

    // main scenarios
    cover property ($rose(chan_a_flag_high));
    cover property ($rose(q.emb[3]));
    cover property ($rose(irq));
    cover property (pslverr);
    cover property (mag_valid[0] && win_end && q.sel == 3'h2);
endmodule
`default_nettype wire

// [sim/ovd_gain_model.sv]
// far-side gain control model watching the four flag pins
`timescale 1ns/1ps
`default_nettype none
module ovd_gain_model (
    // mode chosen by the bench
    input wire logic single_mode,
    // flag pins from the detector
    input wire logic chan_a_flag_high,
    input wire logic chan_a_flag_low,
    input wire logic chan_b_flag_high,
    input wire logic chan_b_flag_low,
    // per-threshold verdicts for the gain loop
    output logic over_high,
    output logic over_low
);
    // single mode: either core may catch the peak, so pins of one threshold are ORed
    always_comb begin
        if (single_mode) begin
            over_high = chan_a_flag_high | chan_b_flag_high;
            over_low = chan_a_flag_low | chan_b_flag_low;
        end else begin
            // dual mode: the loop here only steers channel a
            over_high = chan_a_flag_high;
            over_low = chan_a_flag_low;
        end
    end
endmodule
`default_nettype wire

// [sim/ovd_detector_tb.sv]
// self-checking bench for the overrange detector
`timescale 1ns/1ps
`default_nettype none
`define CHK_EQ(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module ovd_detector_tb;
    import ovd_pkg::*;
    // clock, reset and tallies
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    int num_errors = 0;
    int tests_run = 0;
    int emb_cnt = 0;
    // apb master side
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic err;
    // sample and complex streams
    logic samp_valid = 1'b0;
    logic [11:0] core_code_a = 12'h800;
    logic [11:0] core_code_b = 12'h800;
    logic samp_out_valid;
    logic [11:0] samp_a;
    logic [11:0] samp_b;
    logic cplx_valid = 1'b0;
    logic [15:0] cplx_i_a = 16'h0;
    logic [15:0] cplx_q_a = 16'h0;
    logic [15:0] cplx_i_b = 16'h0;
    logic [15:0] cplx_q_b = 16'h0;
    logic cplx_out_valid;
    logic [15:0] cplx_out_i_a;
    logic [15:0] cplx_out_q_a;
    logic [15:0] cplx_out_i_b;
    logic [15:0] cplx_out_q_b;
    // flag pins, interrupt and far-side verdicts
    logic chan_a_flag_high;
    logic chan_a_flag_low;
    logic chan_b_flag_high;
    logic chan_b_flag_low;
    logic irq;
    logic single_mode = 1'b0;
    logic over_high;
    logic over_low;
    logic [3:0] pins;
    assign pins = {chan_b_flag_low, chan_b_flag_high, chan_a_flag_low, chan_a_flag_high};

    ovd_detector i_ovd_detector (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .samp_valid(samp_valid), .core_code_a(core_code_a), .core_code_b(core_code_b),
        .samp_out_valid(samp_out_valid), .samp_a(samp_a), .samp_b(samp_b),
        .cplx_valid(cplx_valid), .cplx_i_a(cplx_i_a), .cplx_q_a(cplx_q_a),
        .cplx_i_b(cplx_i_b), .cplx_q_b(cplx_q_b), .cplx_out_valid(cplx_out_valid),
        .cplx_out_i_a(cplx_out_i_a), .cplx_out_q_a(cplx_out_q_a),
        .cplx_out_i_b(cplx_out_i_b), .cplx_out_q_b(cplx_out_q_b),
        .chan_a_flag_high(chan_a_flag_high), .chan_a_flag_low(chan_a_flag_low),
        .chan_b_flag_high(chan_b_flag_high), .chan_b_flag_low(chan_b_flag_low), .irq(irq)
    );
    ovd_gain_model i_ovd_gain_model (
        .single_mode(single_mode), .chan_a_flag_high(chan_a_flag_high),
        .chan_a_flag_low(chan_a_flag_low), .chan_b_flag_high(chan_b_flag_high),
        .chan_b_flag_low(chan_b_flag_low), .over_high(over_high), .over_low(over_low)
    );

    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // one apb transfer; ends one edge after release so results have landed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // no latency assumed; only the watchdog ends a wait
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // read and compare a register
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK_EQ(nm, exp, rd)
    endtask

    // one-clock sample pair, idle code around it; output is offset flipped
    task automatic hit(input logic [11:0] a, input logic [11:0] b);
        @(posedge ref_clk);
        core_code_a <= a;
        core_code_b <= b;
        @(posedge ref_clk);
        core_code_a <= 12'h800;
        core_code_b <= 12'h800;
        @(posedge ref_clk);
        `CHK_EQ("samp_a", a ^ 12'h800, samp_a)
        `CHK_EQ("samp_b", b ^ 12'h800, samp_b)
    endtask

    // count cycles the channel a high flag stands
    task automatic meas(input int expn);
        int n;
        int w;
        n = 0;
        w = 0;
        while (chan_a_flag_high !== 1'b1 && w < 10) begin
            w++;
            @(posedge ref_clk);
        end
        while (chan_a_flag_high === 1'b1 && n < 2000) begin
            n++;
            @(posedge ref_clk);
        end
        `CHK_EQ("stretch", expn, n)
    endtask

    // single exit point
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog: whole run is a few thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        end_sim;
    end

    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        samp_valid <= 1'b1;
        rchk(OVD_ADDR_THRESH, 32'h0000ffff, "thresh_rst");
        rchk(OVD_ADDR_CFG, 32'h0, "cfg_rst");
        rchk(OVD_ADDR_IRQ_MASK, 32'h0, "mask_rst");
        apb(1'b0, 8'h14, 32'h0);
        `CHK_EQ("unmapped_err", 1'b1, err)
        `CHK_EQ("unmapped_rd", 32'h0, rd)
        // refused write: only the error response is checked
        apb(1'b1, 8'h14, 32'h0000_0707);
        `CHK_EQ("unmapped_wr", 1'b1, err)
        // full scale both ways must reach 255 and meet the 0xff thresholds
        hit(12'h000, 12'hfff);
        repeat (2) @(posedge ref_clk);
        `CHK_EQ("pins_fs", 4'hf, pins)
        `CHK_EQ("samp_vld", 1'b1, samp_out_valid)
        `CHK_EQ("irq_masked", 1'b0, irq)
        rchk(OVD_ADDR_IRQ_STAT, 32'hf, "stat_fs");
        apb(1'b1, OVD_ADDR_IRQ_MASK, 32'h1);
        `CHK_EQ("irq_on", 1'b1, irq)
        apb(1'b1, OVD_ADDR_IRQ_STAT, 32'h1);
        rchk(OVD_ADDR_IRQ_STAT, 32'he, "stat_w1c");
        `CHK_EQ("irq_off", 1'b0, irq)
        apb(1'b1, OVD_ADDR_IRQ_STAT, 32'he);
        // low 0x40, high 0xf0, shared by both channels
        apb(1'b1, OVD_ADDR_THRESH, 32'h000040f0);
        rchk(OVD_ADDR_THRESH, 32'h000040f0, "thresh_wr");
        // exactly at the low threshold with both signs, one step below it with positive codes only
        hit(12'h9f8, 12'ha00);
        repeat (2) @(posedge ref_clk);
        `CHK_EQ("pins_pos_edge", 4'h8, pins)
        repeat (12) @(posedge ref_clk);
        hit(12'h600, 12'h9f8);
        repeat (2) @(posedge ref_clk);
        `CHK_EQ("pins_neg_edge", 4'h2, pins)
        repeat (12) @(posedge ref_clk);
        // stretch length for every select value
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, OVD_ADDR_CFG, 32'(s));
            hit(12'h000, 12'h800);
            meas(8 << s);
            repeat (4) @(posedge ref_clk);
        end
        // complex words: a over both thresholds, b over low only
        apb(1'b1, OVD_ADDR_CFG, 32'h20);
        core_code_a <= 12'h000;
        core_code_b <= 12'ha00;
        repeat (8) @(posedge ref_clk);
        cplx_valid <= 1'b1;
        cplx_i_a <= 16'hfffe;
        cplx_q_a <= 16'h0000;
        cplx_i_b <= 16'h5555;
        cplx_q_b <= 16'haaaa;
        @(posedge ref_clk);
        cplx_valid <= 1'b0;
        @(posedge ref_clk);
        `CHK_EQ("i_a", 16'hffff, cplx_out_i_a)
        `CHK_EQ("q_a", 16'h0001, cplx_out_q_a)
        `CHK_EQ("i_b", 16'h5554, cplx_out_i_b)
        `CHK_EQ("q_b", 16'haaab, cplx_out_q_b)
        `CHK_EQ("cplx_vld", 1'b1, cplx_out_valid)
        rchk(OVD_ADDR_FLAGS, 32'h0000_00bb, "flags_rd");
        core_code_a <= 12'h800;
        core_code_b <= 12'h800;
        // lone hit at select 2: embedded bit stands one window of four
        apb(1'b1, OVD_ADDR_CFG, 32'h22);
        cplx_valid <= 1'b1;
        hit(12'h000, 12'h800);
        repeat (16) begin
            @(posedge ref_clk);
            emb_cnt += int'(cplx_out_i_a[0]);
        end
        cplx_valid <= 1'b0;
        `CHK_EQ("emb_window", 4, emb_cnt)
        // single mode: hit on b only, far side still sees it
        apb(1'b1, OVD_ADDR_CFG, 32'h10);
        single_mode <= 1'b1;
        repeat (12) @(posedge ref_clk);
        hit(12'h800, 12'h000);
        repeat (2) @(posedge ref_clk);
        `CHK_EQ("far_high", 1'b1, over_high)
        `CHK_EQ("far_low", 1'b1, over_low)
        `CHK_EQ("a_pin_quiet", 1'b0, chan_a_flag_high)
        end_sim;
    end
endmodule
`default_nettype wire
